/* dv/adcl_config_regs_bench.sv */
// self-checking bench of the adc link config bank
`timescale 1ns/100ps
`default_nettype none
module adcl_config_regs_bench import adcl_pkg::*;;
  logic        clk = 1'b0, resetn = 1'b0, run = 1'b0, stall = 1'b0;
  logic        fmt_strap = 1'b1, ref_strap = 1'b1, pat_lo = 1'b0, pat_hi = 1'b0;
  logic        hw_reset, sen_n, sclk, shift_data_in, readback_out_pin, adc_ready, enc_valid;
  logic        adc_valid = 1'b0, enc_ready = 1'b0, m_rev, m_twos;
  logic [1:0]  m_src;
  logic [2:0]  m_pat;
  logic [3:0]  power_estimate = 4'h0, detect_pins;
  logic [7:0]  q, shadow [256];
  logic [11:0] adc_sample = 12'h000;
  logic [15:0] enc_word, exp_q [$];
  logic [26:0] exp_c, got_c;
  logic [31:0] seed = 32'd8810, r, rs, md, exp_w;
  int          failures = 0, check_count = 0, k, takes = 0;
  adcl_pins_t  pins;
  adcl_cfg_t   link_cfg;
  logic [7:0]  addrs [14] = '{8'h02, 8'h3c, 8'h44, 8'h45, 8'ha0, 8'ha1, 8'ha5, 8'hb0, 8'hb4,
                              8'hb6, 8'hb7, 8'hb8, 8'hb9, 8'hd6};
  // stream modes: {straps fmt,hi,lo; 0xa0; 0x45; 0x3c}
  logic [31:0] modes [11] = '{32'h04000000, 32'h04000100, 32'h04000200, 32'h04080000,
                              32'h04000080, 32'h000000c0, 32'h04400000, 32'h04800000,
                              32'h05000000, 32'h04000400, 32'h0400c800};
  assign pins = {hw_reset, sen_n, sclk, shift_data_in, fmt_strap, ref_strap, pat_lo, pat_hi};
  always #2.5 clk = ~clk;
  adcl_config_regs adcl_config_regs_i (.clk, .resetn, .pins, .readback_out_pin, .adc_sample,
    .adc_valid, .adc_ready, .power_estimate, .enc_word, .enc_valid, .enc_ready, .detect_pins,
    .link_cfg);
  adcl_ctl_model adcl_ctl_model_i (.clk, .readback_out_pin, .hw_reset, .sen_n, .sclk, .shift_data_in);
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // word the encoder should see for a sample in the current mode
  function automatic logic [15:0] exp_word(input logic [11:0] s);
    logic [11:0] v;
    v = (m_pat == 3'h1) ? 12'h000 : (m_pat == 3'h2) ? 12'hfff : s;
    if (m_pat == 3'h4) v = 12'(takes >> 2); // ramp climbs one code per four samples
    if (m_twos) v[11] = ~v[11];
    if (m_rev) v = {<<{v}};
    if (m_src == 2'h1) return 16'hb5b5;
    if (m_src == 2'h2) return 16'hff00;
    return {v, 4'h0};
  endfunction
  function automatic logic [31:0] sizes();
    return 32'({link_cfg.scramble_enable, link_cfg.octets_per_frame_m1,
                link_cfg.frames_per_mf_m1});
  endfunction
  task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] unused;
    adcl_ctl_model_i.xfer(a, d, unused);
    shadow[a] = d;
  endtask
  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // bounded wait until every taken sample has left the buffer
  task automatic drain();
    for (k = 0; k < 300 && (exp_q.size() != 0 || adc_valid); k++) @(posedge clk);
    if (k == 300) begin
      failures++;
      stop_test();
    end
  endtask
  ////////////////////////////////////////
  // stream source and sink; a sample stays put until taken
  always @(posedge clk) begin
    rs = rnd();
    if (adc_valid && adc_ready) begin
      exp_q.push_back(exp_word(adc_sample));
      takes++;
    end
    if (enc_valid && enc_ready) begin
      exp_w = exp_q.size() ? 32'(exp_q.pop_front()) : 32'hx;
      check_val("enc_word", exp_w, 32'(enc_word));
    end
    if (!adc_valid || adc_ready) begin
      adc_valid  <= run & rs[0];
      adc_sample <= rs[27:16];
    end
    enc_ready      <= !stall & rs[1];
    power_estimate <= rs[7:4];
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (30) @(posedge clk);
    check_val("frame_sizes", 32'h0028, sizes());
    end_test("defaults");
    foreach (addrs[i]) begin
      r = rnd();
      wr(addrs[i], r[7:0]);
    end
    wr(8'h10, 8'hff); // unmapped, must alias nothing
    wr(8'h00, 8'h01);
    foreach (addrs[i]) begin
      r = rnd();
      adcl_ctl_model_i.xfer(addrs[i], r[7:0], q);
      check_byte("readback", shadow[addrs[i]], q);
    end
    wr(8'h00, 8'h00);
    exp_c = {shadow[8'hb6], shadow[8'hb7][7:6], shadow[8'hb8][7:4], shadow[8'hb9][7:2],
             shadow[8'ha0][5:4], shadow[8'ha0][2:0], shadow[8'ha5][7],
             shadow[8'h44][3] ? shadow[8'h44][2] : ref_strap};
    got_c = {link_cfg.lane_a_override_word, link_cfg.lane_b_override_word,
             link_cfg.alt_sync_idle_enable, link_cfg.link_test_seq_enable,
             link_cfg.multiframe_marker_enable, link_cfg.frame_marker_enable,
             link_cfg.lane_align_seq_enable, link_cfg.scramble_enable, link_cfg.ref_external};
    check_val("link_cfg", 32'(exp_c), 32'(got_c));
    exp_c = 27'({shadow[8'h44][6], shadow[8'h02][6:4], shadow[8'h02][0], shadow[8'hb0][3:0],
                 shadow[8'hb4][6], shadow[8'hb4][3], shadow[8'hd6][5:2], shadow[8'hd6][0]});
    got_c = 27'({link_cfg.soft_powerdown, link_cfg.distortion_tune, link_cfg.line_current,
                 link_cfg.lane_b_override_enable, link_cfg.lane_a_override_enable,
                 link_cfg.power_estimate_enable, link_cfg.power_average_length,
                 link_cfg.coarse_code_output_enable});
    check_val("link_cfg_misc", 32'(exp_c), 32'(got_c));
    end_test("readback");
    wr(8'ha5, 8'h80);
    wr(8'ha1, 8'h00);
    wr(8'ha6, 8'h00);
    check_val("frame_sizes", 32'h2028, sizes());
    wr(8'ha1, 8'h01);
    wr(8'ha6, 8'h00);
    check_val("frame_sizes", 32'h2010, sizes());
    wr(8'ha1, 8'h03);
    wr(8'ha7, 8'h16);
    check_val("frame_sizes", 32'h2016, sizes());
    wr(8'h00, 8'h02);
    check_val("frame_sizes", 32'h0028, sizes());
    wr(8'ha5, 8'h80);
    adcl_ctl_model_i.hw_pulse();
    check_val("frame_sizes", 32'h0028, sizes());
    end_test("frame sizes");
    for (int m = 0; m < 11; m++) begin
      md = modes[m];
      wr(8'ha0, md[23:16]);
      wr(8'h45, md[15:8]);
      wr(8'h3c, md[7:0]);
      wr(8'hd6, (m == 3) ? 8'h01 : (m == 4) ? 8'h20 : 8'h00);
      {fmt_strap, pat_hi, pat_lo} <= md[26:24];
      m_src  = md[23:22] | md[25:24];
      m_pat  = md[10:8];
      m_rev  = md[19];
      m_twos = md[7] ? !md[6] : !md[26];
      repeat (8) @(posedge clk);
      run <= 1'b1;
      repeat (40) @(posedge clk);
      stall <= 1'b1; // sink stalls for 10 cycles, long enough for the buffer to refuse
      repeat (10) @(posedge clk);
      stall <= 1'b0;
      repeat (20) @(posedge clk);
      run <= 1'b0;
      drain();
      end_test("stream mode");
    end
    stop_test();
  end
endmodule // adcl_config_regs_bench
bind adcl_config_regs adcl_regs_checker adcl_regs_checker_i (.clk, .resetn, .pins,
  .readback_out_pin, .adc_sample, .adc_valid, .adc_ready, .power_estimate, .enc_word,
  .enc_valid, .enc_ready, .detect_pins, .link_cfg);
`default_nettype wire

/* dv/adcl_config_regs_properties.sv */
// port-level checks of the adc link config bank
`timescale 1ns/100ps
`default_nettype none
module adcl_regs_checker
  import adcl_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire adcl_pins_t  pins,
  input wire logic        readback_out_pin,
  input wire logic [11:0] adc_sample,
  input wire logic        adc_valid,
  input wire logic        adc_ready,
  input wire logic [3:0]  power_estimate,
  input wire logic [15:0] enc_word,
  input wire logic        enc_valid,
  input wire logic        enc_ready,
  input wire logic [3:0]  detect_pins,
  input wire adcl_cfg_t   link_cfg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  // sample taken at the input; output word stalled by the sink
  sequence s_take;
    adc_valid && adc_ready;
  endsequence
  sequence s_held;
    enc_valid && !enc_ready;
  endsequence
  ////////////////////////////////////////
  a_reset_frame_sizes: assert property (disable iff (1'b0)
    !resetn ##1 !resetn |-> link_cfg.octets_per_frame_m1 == 8'h01
      && link_cfg.frames_per_mf_m1 == 5'h08)
    else $error("frame sizes off during reset");
  a_pin_reset_holds: assert property (
    pins.hw_reset [*8] |-> !link_cfg.scramble_enable && link_cfg.lane_a_override_word == 10'h000
      && link_cfg.octets_per_frame_m1 == 8'h01)
    else $error("settings not held at defaults by reset pin");
  a_readback_quiet: assert property (
    pins.sen_n [*4] |-> !readback_out_pin)
    else $error("readback pin busy while not selected");
  a_word_held: assert property (
    s_held |=> enc_valid && $stable(enc_word))
    else $error("stalled word changed or dropped");
  a_take_answer: assert property (
    s_take ##0 !enc_valid |=> enc_valid)
    else $error("taken sample not offered next cycle");
  a_buffer_refuse: assert property (
    s_held ##0 s_take |=> !adc_ready)
    else $error("full buffer still ready");
  a_coarse_code: assert property (
    link_cfg.coarse_code_output_enable && adc_valid && adc_ready |=>
      !link_cfg.coarse_code_output_enable || {detect_pins, 8'h00} == ($past(adc_sample) & 12'hf00))
    else $error("coarse code wrong on detect pins");
  a_power_level: assert property (
    link_cfg.power_estimate_enable && !link_cfg.coarse_code_output_enable |=>
      link_cfg.coarse_code_output_enable || !link_cfg.power_estimate_enable
      || detect_pins == $past(power_estimate))
    else $error("power estimate wrong on detect pins");
endmodule // adcl_regs_checker
`default_nettype wire

/* dv/adcl_ctl_model.sv */
// serial controller model driving the three-wire port of the bank
`timescale 1ns/100ps
`default_nettype none
module adcl_ctl_model (
  input  wire logic clk,
  input  wire logic readback_out_pin,
  output logic      hw_reset,
  output logic      sen_n,
  output logic      sclk,
  output logic      shift_data_in
);
  // idle: not selected, clock parked low
  initial begin
    hw_reset = 1'b0;
    sen_n    = 1'b1;
    sclk     = 1'b0;
    shift_data_in    = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // 50 ns pulse, then 100 ns quiet before any select
  task automatic hw_pulse();
    @(posedge clk);
    hw_reset <= 1'b1;
    wait_clk(10);
    hw_reset <= 1'b0;
    wait_clk(20);
  endtask
  // one word msb first; 5 clk half periods keep sclk at 20 MHz
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] w;
    w = {a, d};
    q = 8'h00;
    @(posedge clk);
    sen_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      wait_clk(5);
      sclk  <= 1'b1;
      shift_data_in <= w[i];
      wait_clk(5);
      sclk  <= 1'b0;
      if (i < 8) q = {q[6:0], readback_out_pin};
    end
    wait_clk(5);
    sen_n <= 1'b1;
    shift_data_in <= ~shift_data_in; // released line must not keep the last bit
    wait_clk(5);
  endtask
endmodule // adcl_ctl_model
`default_nettype wire

/* verilog/adcl_config_regs.sv */
// serial-port config register bank with sample conditioning for the link encoder
`timescale 1ns/100ps
`default_nettype none
`include "adcl_consts.svh"

module adcl_config_regs
  import adcl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire adcl_pins_t  pins,
  output logic             readback_out_pin,
  input  wire logic [11:0] adc_sample,
  input  wire logic        adc_valid,
  output logic             adc_ready,
  input  wire logic [3:0]  power_estimate,
  output logic [15:0]      enc_word,
  output logic             enc_valid,
  input  wire logic        enc_ready,
  output logic [3:0]       detect_pins,
  output adcl_cfg_t        link_cfg
);

  localparam adcl_regs_t REG_DEF = {121'h0, `ADCL_F_DEF};

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // q10 gain factors, 0 to 6 db in half db steps
  function automatic logic [11:0] gain_q(input logic [3:0] s);
    case (s)
      4'h0:    gain_q = 12'h400;
      4'h1:    gain_q = 12'h43d;
      4'h2:    gain_q = 12'h47d;
      4'h3:    gain_q = 12'h4c1;
      4'h4:    gain_q = 12'h509;
      4'h5:    gain_q = 12'h556;
      4'h6:    gain_q = 12'h5a6;
      4'h7:    gain_q = 12'h5fc;
      4'h8:    gain_q = 12'h657;
      4'h9:    gain_q = 12'h6b7;
      4'ha:    gain_q = 12'h71d;
      4'hb:    gain_q = 12'h789;
      default: gain_q = 12'h7fb; // codes above 6 db clamp to 6 db
    endcase
  endfunction

  // sixteen steps of 1 + x^14 + x^15, word in top, state in bottom
  function automatic logic [30:0] prbs_step(input logic [14:0] p);
    logic [15:0] w;
    logic [14:0] q;
    logic        fb;
    w = 16'h0000;
    q = p;
    for (int i = 0; i < 16; i++) begin
      fb = q[14] ^ q[13];
      w  = {w[14:0], fb};
      q  = {q[13:0], fb};
    end
    prbs_step = {w, q};
  endfunction

  // register contents as seen by readback
  function automatic logic [7:0] rd_byte(input logic [7:0] a,
                                         input adcl_regs_t r);
    case (a)
      `ADCL_A_RST:  rd_byte = {7'h00, r.readback_en};
      `ADCL_A_SFDR: rd_byte = r.distortion_tune_ctrl;
      `ADCL_A_FMT:  rd_byte = r.output_format_ctrl;
      `ADCL_A_REF:  rd_byte = r.reference_powerdown_ctrl;
      `ADCL_A_GAIN: rd_byte = r.gain_pattern_ctrl;
      `ADCL_A_LINK: rd_byte = r.link_options_ctrl;
      `ADCL_A_GATE: rd_byte = r.link_param_write_gates;
      `ADCL_A_SCR:  rd_byte = r.scramble_ctrl;
      `ADCL_A_F:    rd_byte = r.octets_per_frame_reg;
      `ADCL_A_K:    rd_byte = r.frames_per_multiframe_reg;
      `ADCL_A_CML:  rd_byte = r.line_drive_current_reg;
      `ADCL_A_OVR:  rd_byte = r.lane_override_enables;
      `ADCL_A_AWH:  rd_byte = r.lane_a_word_high;
      `ADCL_A_AWL:  rd_byte = r.lane_a_word_low;
      `ADCL_A_BWH:  rd_byte = r.lane_b_word_high;
      `ADCL_A_BWL:  rd_byte = r.lane_b_word_low;
      `ADCL_A_DET:  rd_byte = r.level_detect_ctrl;
      default:      rd_byte = 8'h00;
    endcase
  endfunction

  // one committed serial word
  function automatic adcl_regs_t reg_write(input adcl_regs_t r,
                                           input logic [7:0] a,
                                           input logic [7:0] d);
    reg_write = r;
    if (a == `ADCL_A_RST) begin
      // soft reset only when writes are open; bit reads back as zero
      if (d[`ADCL_B_SOFT_RST] && !r.readback_en) begin
        reg_write = REG_DEF;
      end else begin
        reg_write.readback_en = d[`ADCL_B_READBACK];
      end
    end else if (!r.readback_en) begin
      case (a)
        `ADCL_A_SFDR: reg_write.distortion_tune_ctrl     = d;
        `ADCL_A_FMT:  reg_write.output_format_ctrl       = d;
        `ADCL_A_REF:  reg_write.reference_powerdown_ctrl = d;
        `ADCL_A_GAIN: reg_write.gain_pattern_ctrl        = d;
        `ADCL_A_LINK: reg_write.link_options_ctrl        = d;
        `ADCL_A_GATE: reg_write.link_param_write_gates   = d;
        `ADCL_A_SCR:  reg_write.scramble_ctrl            = d;
        `ADCL_A_F: begin
          if (r.link_param_write_gates[`ADCL_B_FGATE]) begin
            reg_write.octets_per_frame_reg = d;
          end
        end
        `ADCL_A_K: begin
          if (r.link_param_write_gates[`ADCL_B_KGATE]) begin
            reg_write.frames_per_multiframe_reg = d;
          end
        end
        `ADCL_A_CML:  reg_write.line_drive_current_reg   = d;
        `ADCL_A_OVR:  reg_write.lane_override_enables    = d;
        `ADCL_A_AWH:  reg_write.lane_a_word_high         = d;
        `ADCL_A_AWL:  reg_write.lane_a_word_low          = d;
        `ADCL_A_BWH:  reg_write.lane_b_word_high         = d;
        `ADCL_A_BWL:  reg_write.lane_b_word_low          = d;
        `ADCL_A_DET:  reg_write.level_detect_ctrl        = d;
        default: ; // unmapped addresses are dropped
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_q;
  logic       rst_n;

  // async assert, two-flop release
  // a release that lands near an edge would otherwise let some flops
  // leave reset one clock before the others
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  ////////////////////////////////////////////////////////////////////////
  // next state

  adcl_state_t        st_r;
  adcl_state_t        st_nxt;
  logic               fall;
  logic               take;
  logic               pop;
  logic               fmt_ob;
  logic [1:0]         src;
  logic [2:0]         pat;
  logic signed [24:0] prod;
  logic signed [24:0] shf;
  logic [11:0]        gained;
  logic [11:0]        code;
  logic [11:0]        out12;
  logic [11:0]        rev12;
  logic [15:0]        word;
  logic [30:0]        pr;
  adcl_regs_t         rg;

  // bit reversal of the sample, padding untouched
  for (genvar gi = 0; gi < 12; gi++) begin : g_rev
    assign rev12[gi] = out12[11 - gi];
  end

  always_comb begin
    st_nxt = st_r;
    rg     = st_r.regs;
    // pins pass two flops; edge detect looks only at the second
    st_nxt.s1     = pins;
    st_nxt.s2     = st_r.s1;
    st_nxt.sclk_d = st_r.s2.sclk;
    fall = st_r.sclk_d & ~st_r.s2.sclk & ~st_r.s2.sen_n;

    // serial shifter: address first, data second
    // sclk is only sampled, so half periods under one clock can be lost
    if (st_r.s2.sen_n) begin
      st_nxt.cnt = 4'h0; // partial words are dropped
    end else if (fall) begin
      st_nxt.sh  = {st_r.sh[14:0], st_r.s2.shift_data_in};
      st_nxt.cnt = st_r.cnt + 4'h1;
      if (st_r.cnt == `ADCL_ADDR_LAST) begin
        st_nxt.rd = rd_byte(st_nxt.sh[7:0], st_r.regs);
      end else if (st_r.cnt[3]) begin
        st_nxt.rd = {st_r.rd[6:0], 1'b0};
      end
      if (st_r.cnt == `ADCL_WORD_LAST) begin
        st_nxt.regs = reg_write(st_r.regs, st_nxt.sh[15:8], st_nxt.sh[7:0]);
      end
    end
    // pin changes right after the controller's capture edge
    // the byte is latched once the address is in, so a register that
    // changes mid-read does not tear the value being shifted out
    st_nxt.sdo = st_nxt.regs.readback_en & st_nxt.cnt[3] & st_nxt.rd[7];
    // reset pin wins over a word committed in the same cycle
    if (st_r.s2.hw_reset) begin
      st_nxt.regs = REG_DEF;
      st_nxt.cnt  = 4'h0;
    end

    // effective modes: format from register override or strap, source or-ed from both, pattern from register
    fmt_ob = rg.output_format_ctrl[`ADCL_B_FMT_OVR] ?
             rg.output_format_ctrl[`ADCL_B_FMT_SEL] : st_r.s2.fmt_strap;
    src = rg.link_options_ctrl[7:6] | {st_r.s2.pat_hi, st_r.s2.pat_lo};
    pat = rg.gain_pattern_ctrl[2:0];

    // gain on the centred sample with saturation
    // centring scales about mid-scale; saturation keeps a large
    // sample from wrapping to the opposite rail
    prod = $signed({~adc_sample[11], adc_sample[10:0]}) *
           $signed({1'b0, gain_q(rg.gain_pattern_ctrl[7:4])});
    shf  = prod >>> `ADCL_GAIN_Q;
    if (shf > 25'sh0007ff) begin
      gained = 12'h7ff;
    end else if (shf < 25'sh1fff800) begin
      gained = 12'h800;
    end else begin
      gained = shf[11:0];
    end
    gained = {~gained[11], gained[10:0]};
    if (rg.gain_pattern_ctrl[`ADCL_B_GBYP]) begin
      gained = adc_sample;
    end

    // test patterns, codes in offset binary
    case (pat)
      `ADCL_PAT_MIN:  code = `ADCL_CODE_MIN;
      `ADCL_PAT_MAX:  code = `ADCL_CODE_MAX;
      `ADCL_PAT_RAMP: code = st_r.ramp;
      default:        code = gained; // unused codes pass data
    endcase
    out12 = fmt_ob ? code : {~code[11], code[10:0]};

    // encoder source
    // straps and register bits are or-ed, so either can pick a source
    pr = prbs_step(st_r.prbs);
    case (src)
      `ADCL_SRC_ADC: begin
        word = rg.link_options_ctrl[3] ? {rev12, 4'h0} : {out12, 4'h0};
      end
      `ADCL_SRC_B5B5: word = `ADCL_WORD_B5B5;
      `ADCL_SRC_FF00: word = `ADCL_WORD_FF00;
      default:        word = pr[30:15]; // independent of scrambling
    endcase

    // two-entry buffer; receiver stall backs up to adc_ready
    // adc_ready comes from a flop, so the second entry catches the
    // sample already offered when the receiver stops
    take = adc_valid & st_r.rdy;
    pop  = st_r.hv & enc_ready;
    if (pop) begin
      st_nxt.hv = st_r.tv;
      st_nxt.hd = st_r.td;
      st_nxt.tv = 1'b0;
    end
    if (take) begin
      if (!st_nxt.hv) begin
        st_nxt.hv = 1'b1;
        st_nxt.hd = word;
      end else begin
        st_nxt.tv = 1'b1;
        st_nxt.td = word;
      end
      // ramp steps every fourth sample, wraps to min
      // patterns advance per taken sample, so a stall skips no word
      st_nxt.ramp_div = st_r.ramp_div + 2'h1;
      if (st_r.ramp_div == `ADCL_RAMP_LAST) begin
        st_nxt.ramp = st_r.ramp + 12'h001;
      end
      st_nxt.prbs = pr[14:0];
    end
    st_nxt.rdy = ~st_nxt.tv;

    // detect pins
    if (rg.level_detect_ctrl[`ADCL_B_COARSE]) begin
      st_nxt.det = take ? adc_sample[11:8] : st_r.det;
    end else if (rg.level_detect_ctrl[`ADCL_B_PWR]) begin
      st_nxt.det = power_estimate;
    end else begin
      st_nxt.det = 4'h0;
    end

    // settings for the transmitter, one cycle behind the registers
    // registering them keeps the long decode paths off the outputs
    st_nxt.cfg.ref_external = rg.reference_powerdown_ctrl[`ADCL_B_REF_OVR] ?
      rg.reference_powerdown_ctrl[`ADCL_B_REF_SEL] : st_r.s2.ref_strap;
    st_nxt.cfg.soft_powerdown  = rg.reference_powerdown_ctrl[`ADCL_B_PDN];
    st_nxt.cfg.distortion_tune = {rg.distortion_tune_ctrl[6:4], rg.distortion_tune_ctrl[0]};
    st_nxt.cfg.line_current    = rg.line_drive_current_reg[3:0];
    st_nxt.cfg.lane_align_seq_enable    = rg.link_options_ctrl[0];
    st_nxt.cfg.frame_marker_enable      = rg.link_options_ctrl[1];
    st_nxt.cfg.multiframe_marker_enable = rg.link_options_ctrl[2];
    st_nxt.cfg.link_test_seq_enable     = rg.link_options_ctrl[4];
    st_nxt.cfg.alt_sync_idle_enable     = rg.link_options_ctrl[5];
    st_nxt.cfg.scramble_enable = rg.scramble_ctrl[`ADCL_B_SCR];
    st_nxt.cfg.octets_per_frame_m1 = rg.octets_per_frame_reg;
    if (rg.link_param_write_gates[`ADCL_B_KGATE]) begin
      st_nxt.cfg.frames_per_mf_m1 = rg.frames_per_multiframe_reg[4:0];
    end else begin
      st_nxt.cfg.frames_per_mf_m1 = (rg.octets_per_frame_reg == 8'h00) ?
                                    `ADCL_K_DEF_F0 : `ADCL_K_DEF_F1;
    end
    st_nxt.cfg.lane_a_override_enable = rg.lane_override_enables[`ADCL_B_A_OVR];
    st_nxt.cfg.lane_b_override_enable = rg.lane_override_enables[`ADCL_B_B_OVR];
    st_nxt.cfg.lane_a_override_word = {rg.lane_a_word_high, rg.lane_a_word_low[7:6]};
    st_nxt.cfg.lane_b_override_word = {rg.lane_b_word_high[7:4], rg.lane_b_word_low[7:2]};
    st_nxt.cfg.coarse_code_output_enable = rg.level_detect_ctrl[`ADCL_B_COARSE];
    st_nxt.cfg.power_estimate_enable     = rg.level_detect_ctrl[`ADCL_B_PWR];
    st_nxt.cfg.power_average_length      = rg.level_detect_ctrl[4:2];
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= '0;
      st_r.regs <= REG_DEF;
      st_r.prbs <= `ADCL_PRBS_SEED; // lfsr must never sit at zero
      st_r.cfg.octets_per_frame_m1 <= `ADCL_F_DEF;
      st_r.cfg.frames_per_mf_m1    <= `ADCL_K_DEF_F1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from state flops
  assign readback_out_pin = st_r.sdo;
  assign adc_ready        = st_r.rdy;
  assign enc_word         = st_r.hd;
  assign enc_valid        = st_r.hv;
  assign detect_pins      = st_r.det;
  assign link_cfg         = st_r.cfg;

endmodule // adcl_config_regs
`default_nettype wire

/* verilog/adcl_consts.svh */
// register offsets, field positions, defaults and counts of the adc link config bank
`ifndef ADCL_CONSTS_SVH
`define ADCL_CONSTS_SVH
// register offsets on the serial port
`define ADCL_A_RST      8'h00
`define ADCL_A_SFDR     8'h02
`define ADCL_A_FMT      8'h3c
`define ADCL_A_REF      8'h44
`define ADCL_A_GAIN     8'h45
`define ADCL_A_LINK     8'ha0
`define ADCL_A_GATE     8'ha1
`define ADCL_A_SCR      8'ha5
`define ADCL_A_F        8'ha6
`define ADCL_A_K        8'ha7
`define ADCL_A_CML      8'hb0
`define ADCL_A_OVR      8'hb4
`define ADCL_A_AWH      8'hb6
`define ADCL_A_AWL      8'hb7
`define ADCL_A_BWH      8'hb8
`define ADCL_A_BWL      8'hb9
`define ADCL_A_DET      8'hd6
// field positions
`define ADCL_B_READBACK 0
`define ADCL_B_SOFT_RST 1
`define ADCL_B_FMT_OVR  7
`define ADCL_B_FMT_SEL  6
`define ADCL_B_REF_OVR  3
`define ADCL_B_REF_SEL  2
`define ADCL_B_PDN      6
`define ADCL_B_GBYP     3
`define ADCL_B_SCR      7
`define ADCL_B_FGATE    0
`define ADCL_B_KGATE    1
`define ADCL_B_A_OVR    3
`define ADCL_B_B_OVR    6
`define ADCL_B_COARSE   0
`define ADCL_B_PWR      5
// reset values and derived defaults
`define ADCL_F_DEF      8'h01
`define ADCL_K_DEF_F0   5'h10
`define ADCL_K_DEF_F1   5'h08
`define ADCL_PRBS_SEED  15'h7fff
// test patterns and encoder sources
`define ADCL_PAT_PASS   3'h0
`define ADCL_PAT_MIN    3'h1
`define ADCL_PAT_MAX    3'h2
`define ADCL_PAT_RAMP   3'h4
`define ADCL_CODE_MIN   12'h000
`define ADCL_CODE_MAX   12'hfff
`define ADCL_SRC_ADC    2'h0
`define ADCL_SRC_B5B5   2'h1
`define ADCL_SRC_FF00   2'h2
`define ADCL_WORD_B5B5  16'hb5b5
`define ADCL_WORD_FF00  16'hff00
// serial word and sample timing counts, gain fraction bits
`define ADCL_ADDR_LAST  4'h7
`define ADCL_WORD_LAST  4'hf
`define ADCL_RAMP_LAST  2'h3
`define ADCL_GAIN_Q     10
`endif

/* verilog/adcl_pkg.sv */
// types of the adc link config bank
package adcl_pkg;
  // pins from outside, all asynchronous to clk
  typedef struct packed {
    logic hw_reset;
    logic sen_n;
    logic sclk;
    logic shift_data_in;
    logic fmt_strap;
    logic ref_strap;
    logic pat_lo;
    logic pat_hi;
  } adcl_pins_t;

  // register storage; octets_per_frame_reg last so its default sits low
  typedef struct packed {
    logic       readback_en;
    logic [7:0] distortion_tune_ctrl;
    logic [7:0] output_format_ctrl;
    logic [7:0] reference_powerdown_ctrl;
    logic [7:0] gain_pattern_ctrl;
    logic [7:0] link_options_ctrl;
    logic [7:0] link_param_write_gates;
    logic [7:0] scramble_ctrl;
    logic [7:0] frames_per_multiframe_reg;
    logic [7:0] line_drive_current_reg;
    logic [7:0] lane_override_enables;
    logic [7:0] lane_a_word_high;
    logic [7:0] lane_a_word_low;
    logic [7:0] lane_b_word_high;
    logic [7:0] lane_b_word_low;
    logic [7:0] level_detect_ctrl;
    logic [7:0] octets_per_frame_reg;
  } adcl_regs_t;

  // settings handed to the link transmitter and analog side
  typedef struct packed {
    logic       ref_external;
    logic       soft_powerdown;
    logic [3:0] distortion_tune;
    logic [3:0] line_current;
    logic       lane_align_seq_enable;
    logic       frame_marker_enable;
    logic       multiframe_marker_enable;
    logic       link_test_seq_enable;
    logic       alt_sync_idle_enable;
    logic       scramble_enable;
    logic [7:0] octets_per_frame_m1;
    logic [4:0] frames_per_mf_m1;
    logic       lane_a_override_enable;
    logic       lane_b_override_enable;
    logic [9:0] lane_a_override_word;
    logic [9:0] lane_b_override_word;
    logic       coarse_code_output_enable;
    logic       power_estimate_enable;
    logic [2:0] power_average_length;
  } adcl_cfg_t;

  // whole module state
  typedef struct packed {
    adcl_pins_t  s1;
    adcl_pins_t  s2;
    logic        sclk_d;
    logic [15:0] sh;
    logic [3:0]  cnt;
    logic [7:0]  rd;
    logic        sdo;
    adcl_regs_t  regs;
    adcl_cfg_t   cfg;
    logic        hv;
    logic        tv;
    logic        rdy;
    logic [15:0] hd;
    logic [15:0] td;
    logic [11:0] ramp;
    logic [1:0]  ramp_div;
    logic [14:0] prbs;
    logic [3:0]  det;
  } adcl_state_t;
endpackage
